/* design/pmtc_pkg.sv */
// package: register map, field positions and constants for power mode and tick control
package pmtc_pkg;
    // avalon word addresses (register index = printed offset)
    localparam logic [7:0] ADDR_ENTRY = 8'h87;
    localparam logic [7:0] ADDR_STATE = 8'hbe;
    localparam logic [7:0] ADDR_CLOCK = 8'hc6;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hd0;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hd1;
    localparam logic [7:0] ADDR_TEST_BAD = 8'hd2;

    // power entry register fields
    localparam int ENTRY_STROBE_BIT = 0;
    localparam int ENTRY_ZERO_BIT = 1;
    localparam logic [7:0] ENTRY_RW_MASK = 8'hfc;
    localparam logic [7:0] ENTRY_RESET = 8'h00;

    // power state register fields
    localparam int STATE_USB_BIT = 7;
    localparam int STATE_XTAL_STB_BIT = 6;
    localparam int STATE_RC_STB_BIT = 5;
    localparam int STATE_PD_BIT = 2;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic PD_RESET = 1'b1;

    // clock setup register fields
    localparam int CLK_SRC_BIT = 6;
    localparam int TICK_LSB = 3;
    localparam int SPD_LSB = 0;
    localparam logic [7:0] CLOCK_RESET = 8'hc9;

    // interrupt status bits
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_ENTRY_BIT = 1;
    localparam int IRQ_TICK_BAD_BIT = 2;
    localparam int IRQ_W = 3;

    localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
    localparam logic [31:0] BUS_UNMAPPED = 32'hdead_beef;

    typedef enum logic [3:0] {
        PM_FULL_RUN = 4'b0001,
        PM_LIGHT_SLEEP = 4'b0010,
        PM_DEEP_SLEEP = 4'b0100,
        PM_HALT_ALL = 4'b1000
    } pmtc_pm_type;

    localparam logic [1:0] SEL_FULL_RUN = 2'b00;
    localparam logic [1:0] SEL_LIGHT_SLEEP = 2'b01;
    localparam logic [1:0] SEL_DEEP_SLEEP = 2'b10;
    localparam logic [1:0] SEL_HALT_ALL = 2'b11;
endpackage

/* design/pmtc_tick_gen.sv */
// tick enable generator: one-cycle pulse every 2^divider clocks
`timescale 1ns/1ps
module pmtc_tick_gen #(
    parameter int SEL_W = 3,
    parameter int CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [SEL_W-1:0] divider,
    output logic tick
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic [CNT_W-1:0] limit;

    always_comb begin
        limit = CNT_W'((1 << divider) - 1);
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!run) begin
            cnt_d = '0;
        end else if (cnt_q >= limit) begin
            // single-cycle pulse, counter restarts
            cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule // pmtc_tick_gen

/* design/pmtc_top.sv */
// power mode and timer tick control with avalon-mm register slave
// Notes on behaviour
// - shared timer tick enable, eight rates from full system rate down to 1/128
// - upper 4096-byte data range keeps contents in deep sleep and halt
// - 350-byte sub-range is lost on deep entry, undefined after return
// - processor, peripheral and radio registers kept through deep modes
// - writing one to entry strobe starts selected power state; reads zero
// - entry register bit 1 reads zero; bits 7:2 plain storage, reset zero
// - state select field 00 run, 01 light, 10 deep, 11 halt
// - bit 6 reads one only while crystal powered and stable
// - bit 5 reads one only while fast rc powered and stable
// - power-down bit, reset one, stops unused oscillator; zero keeps both
// - power-down bit cleared whenever source select bit changes
// - setting power-down during calibration is deferred until it ends
// - bit 7 enables usb function, reset zero, ignored without usb
// - pin, sleep timer (not halt) or power-on wake to run, clear select
// - after light sleep run on rc until crystal settled and selected
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module pmtc_top
    import pmtc_pkg::*;
#(
    parameter logic HAS_USB = 1'b1,
    parameter int TICK_CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic xtal_ready,
    input wire logic rc_ready,
    input wire logic calib_busy,
    input wire logic wake_pin_irq,
    input wire logic wake_timer_irq,
    output logic timer_tick,
    output logic xtal_power_en,
    output logic rc_power_en,
    output logic main_src_rc,
    output logic [2:0] system_clock_divider,
    output logic usb_enable,
    output logic retain_upper_ram,
    output logic scrub_sub_range,
    output logic regulator_on,
    output logic [1:0] power_state,
    output logic irq
);
    import pmtc_pkg::*;

    // register state
    logic [7:0] entry_q, entry_d;
    logic [1:0] mode_q, mode_d;
    logic usb_q, usb_d;
    logic pd_q, pd_d;
    logic pd_pend_q, pd_pend_d;
    logic [7:0] clk_q, clk_d;
    logic [IRQ_W-1:0] ist_q, ist_d;
    logic [IRQ_W-1:0] imask_q, imask_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    pmtc_pm_type pm_q, pm_d;
    logic rc_sel_q, rc_sel_d;
    logic xstb_q, rstb_q, irq_q;
    logic tick_raw;

    logic wr_en, rd_en;
    logic [2:0] tick_sel;
    logic strobe;
    logic wake;
    logic [IRQ_W-1:0] ev;

    // one wait cycle: request answered on the second edge
    assign wr_en = avs_write && !ack_q && avs_byteenable[0];
    assign rd_en = avs_read && !ack_q;
    assign tick_sel = clk_q[TICK_LSB +: 3];

    assign strobe = wr_en && (avs_address == ADDR_ENTRY) && avs_writedata[ENTRY_STROBE_BIT];
    // wake sources, sleep timer ignored in halt
    assign wake = (pm_q != PM_FULL_RUN)
        && (wake_pin_irq || (wake_timer_irq && pm_q != PM_HALT_ALL));

    always_comb begin
        ev = '0;
        ev[IRQ_WAKE_BIT] = wake;
        ev[IRQ_ENTRY_BIT] = strobe && (mode_q != SEL_FULL_RUN);
        // flag a faster tick than system clock
        ev[IRQ_TICK_BAD_BIT] = tick_sel < clk_q[SPD_LSB +: 3];
    end

    // bus and register next-state
    always_comb begin
        entry_d = entry_q;
        mode_d = mode_q;
        usb_d = usb_q;
        pd_d = pd_q;
        pd_pend_d = pd_pend_q;
        clk_d = clk_q;
        imask_d = imask_q;
        ist_d = ist_q;
        ack_d = (avs_read || avs_write) && !ack_q;
        rdata_d = rdata_q;
        if (wr_en) begin
            case (avs_address)
                ADDR_ENTRY: begin
                    entry_d = avs_writedata[7:0] & ENTRY_RW_MASK;
                end
                ADDR_STATE: begin
                    mode_d = avs_writedata[1:0];
                    usb_d = avs_writedata[STATE_USB_BIT];
                    if (avs_writedata[STATE_PD_BIT] && calib_busy) begin
                        pd_pend_d = 1'b1;
                    end else begin
                        pd_d = avs_writedata[STATE_PD_BIT];
                        pd_pend_d = 1'b0;
                    end
                end
                ADDR_CLOCK: begin
                    clk_d = avs_writedata[7:0];
                    if (avs_writedata[CLK_SRC_BIT] != clk_q[CLK_SRC_BIT]) begin
                        pd_d = 1'b0;
                        pd_pend_d = 1'b0;
                    end
                end
                ADDR_IRQ_STATUS: ist_d = ist_q & ~avs_writedata[IRQ_W-1:0];
                ADDR_IRQ_MASK: imask_d = avs_writedata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
        // apply deferred set at calibration end
        if (pd_pend_d && !calib_busy) begin
            pd_d = 1'b1;
            pd_pend_d = 1'b0;
        end
        if (wake) begin
            mode_d = SEL_FULL_RUN;
        end
        // event set wins over write-one-to-clear
        ist_d = ist_d | ev;
        if (rd_en) begin
            case (avs_address)
                // bit 1 and strobe read zero
                ADDR_ENTRY: rdata_d = {24'h00_0000, entry_q};
                // live stable flags; reserved bits zero
                ADDR_STATE: rdata_d = {24'h00_0000, usb_q, xstb_q, rstb_q, 2'b00, pd_q, mode_q};
                ADDR_CLOCK: rdata_d = {24'h00_0000, clk_q};
                ADDR_IRQ_STATUS: rdata_d = {29'h0000_0000, ist_q};
                ADDR_IRQ_MASK: rdata_d = {29'h0000_0000, imask_q};
                default: rdata_d = BUS_UNMAPPED;
            endcase
        end
    end

    // power state machine
    always_comb begin
        pm_d = pm_q;
        rc_sel_d = rc_sel_q;
        case (pm_q)
            PM_FULL_RUN: begin
                if (strobe) begin
                    case (mode_q)
                        SEL_LIGHT_SLEEP: pm_d = PM_LIGHT_SLEEP;
                        SEL_DEEP_SLEEP: pm_d = PM_DEEP_SLEEP;
                        SEL_HALT_ALL: pm_d = PM_HALT_ALL;
                        default: pm_d = PM_FULL_RUN;
                    endcase
                end
                // leave rc once crystal settled and chosen
                if (rc_sel_q && xtal_ready && !clk_q[CLK_SRC_BIT]) begin
                    rc_sel_d = 1'b0;
                end
            end
            PM_LIGHT_SLEEP: begin
                if (wake) begin
                    pm_d = PM_FULL_RUN;
                    rc_sel_d = 1'b1;
                end
            end
            PM_DEEP_SLEEP, PM_HALT_ALL: begin
                if (wake) begin
                    pm_d = PM_FULL_RUN;
                    rc_sel_d = 1'b1;
                end
            end
            default: pm_d = PM_FULL_RUN;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            entry_q <= ENTRY_RESET;
            mode_q <= MODE_RESET;
            usb_q <= 1'b0;
            pd_q <= PD_RESET;
            pd_pend_q <= 1'b0;
            clk_q <= CLOCK_RESET;
            ist_q <= '0;
            imask_q <= '0;
            ack_q <= 1'b0;
            rdata_q <= BUS_ZERO;
            pm_q <= PM_FULL_RUN;
            rc_sel_q <= 1'b1;
            xstb_q <= 1'b0;
            rstb_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            entry_q <= entry_d;
            mode_q <= mode_d;
            usb_q <= usb_d;
            pd_q <= pd_d;
            pd_pend_q <= pd_pend_d;
            clk_q <= clk_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            pm_q <= pm_d;
            rc_sel_q <= rc_sel_d;
            xstb_q <= xtal_ready && xtal_power_en;
            rstb_q <= rc_ready && rc_power_en;
            irq_q <= |(ist_d & imask_d);
        end
    end

    // tick generator, gated off while asleep
    pmtc_tick_gen #(
        .SEL_W(3),
        .CNT_W(TICK_CNT_W)
    ) u_tick (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(pm_q == PM_FULL_RUN),
        .divider(tick_sel),
        .tick(tick_raw)
    );

    logic run_st;
    logic deep_st;
    assign run_st = (pm_q == PM_FULL_RUN);
    assign deep_st = (pm_q == PM_DEEP_SLEEP) || (pm_q == PM_HALT_ALL);

    // outputs registered; oscillator enables derived from flops
    logic xpw_q, rpw_q, src_q, usb_out_q, keep_q, scrub_q, reg_q;
    logic [2:0] spd_q;
    logic [1:0] pst_q;
    logic tick_q;
    logic src_eff;
    // effective source forced to rc until crystal selected
    assign src_eff = clk_q[CLK_SRC_BIT] || rc_sel_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            xpw_q <= 1'b0;
            rpw_q <= 1'b1;
            src_q <= 1'b1;
            usb_out_q <= 1'b0;
            keep_q <= 1'b1;
            scrub_q <= 1'b0;
            reg_q <= 1'b1;
            spd_q <= CLOCK_RESET[SPD_LSB +: 3];
            pst_q <= 2'h0;
            tick_q <= 1'b0;
        end else begin
            // power down unselected oscillator while set; both off outside run
            xpw_q <= run_st && !(pd_q && src_eff);
            rpw_q <= run_st && !(pd_q && !src_eff);
            src_q <= src_eff;
            // no effect on variants without usb
            usb_out_q <= usb_q && HAS_USB;
            keep_q <= 1'b1;
            scrub_q <= deep_st;
            reg_q <= !deep_st;
            spd_q <= clk_q[SPD_LSB +: 3];
            pst_q <= {pm_q[2] | pm_q[3], pm_q[1] | pm_q[3]};
            tick_q <= tick_raw;
        end
    end

    assign xtal_power_en = xpw_q;
    assign rc_power_en = rpw_q;
    assign main_src_rc = src_q;
    assign system_clock_divider = spd_q;
    assign usb_enable = usb_out_q;
    assign retain_upper_ram = keep_q;
    assign scrub_sub_range = scrub_q;
    assign regulator_on = reg_q;
    assign power_state = pst_q;
    assign timer_tick = tick_q;
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = !ack_q;
    assign irq = irq_q;
endmodule // pmtc_top

/* tb/pmtc_top_asserts.sv */
// checker: port-level properties of power mode and tick control
`timescale 1ns/1ps
module pmtc_top_asserts
    import pmtc_pkg::*;
#(
    parameter logic HAS_USB = 1'b1,
    parameter int TICK_CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic wake_pin_irq,
    input wire logic wake_timer_irq,
    input wire logic usb_enable,
    input wire logic retain_upper_ram,
    input wire logic scrub_sub_range,
    input wire logic regulator_on,
    input wire logic [1:0] power_state
);
    logic strobe_wr;
    logic state_wr;
    assign strobe_wr = avs_write && avs_byteenable[0] && avs_address == ADDR_ENTRY
        && avs_writedata[ENTRY_STROBE_BIT];
    assign state_wr = avs_write && avs_address == ADDR_STATE;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence s_leave_run;
        power_state == SEL_FULL_RUN ##1 power_state != SEL_FULL_RUN;
    endsequence
    sequence s_wake;
        power_state != SEL_FULL_RUN
            && (wake_pin_irq || (wake_timer_irq && power_state != SEL_HALT_ALL));
    endsequence

    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer cycle longer than one clock");
    a_entry_reads_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == ADDR_ENTRY
            |-> avs_readdata[1:0] == 2'b00 && avs_readdata[31:8] == 24'h00_0000)
        else $error("entry register low bits or upper bits not zero");
    a_entry_by_strobe: assert property (
        s_leave_run |-> $past(strobe_wr) || $past(strobe_wr, 2))
        else $error("sleep entered without a strobe write");
    a_wake_to_run: assert property (s_wake |-> ##[1:2] power_state == SEL_FULL_RUN)
        else $error("wake event did not return to run");
    a_halt_ignores_timer: assert property (
        power_state == SEL_HALT_ALL && !wake_pin_irq && !$past(wake_pin_irq)
            |=> power_state == SEL_HALT_ALL)
        else $error("halt state left without pin wake");
    a_ram_retained: assert property (retain_upper_ram)
        else $error("upper data range not retained");
    a_deep_scrub: assert property (
        power_state[1] |-> ##[0:1] (scrub_sub_range && !regulator_on))
        else $error("sub range not scrubbed in deep state");
    a_usb_by_write: assert property (
        $changed(usb_enable) |-> HAS_USB && ($past(state_wr) || $past(state_wr, 2)))
        else $error("usb enable changed without state write");
endmodule // pmtc_top_asserts

/* tb/pmtc_top_tb.sv */
// testbench: register-level checks of power mode and tick control
`timescale 1ns/1ps
module pmtc_top_tb;
    import pmtc_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h1;
    logic xtal_ready = 1'b0;
    logic rc_ready = 1'b1;
    logic calib_busy = 1'b0;
    logic wake_pin_irq = 1'b0;
    logic wake_timer_irq = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, timer_tick, xtal_power_en, rc_power_en, main_src_rc, usb_enable;
    logic retain_upper_ram, scrub_sub_range, regulator_on, irq;
    logic [2:0] system_clock_divider;
    logic [1:0] power_state;
    logic [31:0] rd;
    logic prev;
    int cnt;
    int n_errors = 0;
    int tests_run = 0;

    always #5 clk_sys = ~clk_sys;

    pmtc_top #(.HAS_USB(1'b1), .TICK_CNT_W(8)) pmtc_top_i (.*);

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // one wait state per transfer
        check("bus wait", 32'(n), 32'h0000_0002);
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask

    task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 8'h00, 4'h1);
        check(s, rd & m, e);
    endtask

    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rdc("entry rst", ADDR_ENTRY, 32'hffff_ffff, 32'h0000_0000);
        rdc("state rst", ADDR_STATE, 32'hffff_ffe7, 32'h0000_0024);
        check("xtal off", 32'(xtal_power_en), 32'h0000_0000);
        rdc("unmapped", ADDR_TEST_BAD, 32'hffff_ffff, BUS_UNMAPPED);
        wr(ADDR_ENTRY, 8'hfe);
        bus(1'b1, ADDR_ENTRY, 8'h00, 4'h0);
        rdc("entry rw", ADDR_ENTRY, 32'hffff_ffff, 32'h0000_00fc);
        wr(ADDR_ENTRY, 8'h00);
        xtal_ready <= 1'b1;
        rdc("xtal unpowered", ADDR_STATE, 32'h0000_0040, 32'h0000_0000);
        wr(ADDR_STATE, 8'h80);
        check("usb", 32'(usb_enable), 32'h0000_0001);
        check("xtal on", 32'(xtal_power_en), 32'h0000_0001);
        rc_ready <= 1'b0;
        // flags lag one clock behind the pins
        @(posedge clk_sys);
        rdc("flags", ADDR_STATE, 32'h0000_00e4, 32'h0000_00c0);
        rc_ready <= 1'b1;
        calib_busy <= 1'b1;
        wr(ADDR_STATE, 8'h04);
        rdc("pd deferred", ADDR_STATE, 32'h0000_0004, 32'h0000_0000);
        calib_busy <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rdc("pd late", ADDR_STATE, 32'h0000_0004, 32'h0000_0004);
        check("rc kept", 32'(rc_power_en), 32'h0000_0001);
        check("xtal pd", 32'(xtal_power_en), 32'h0000_0000);
        wr(ADDR_CLOCK, 8'h89);
        rdc("pd on toggle", ADDR_STATE, 32'h0000_0004, 32'h0000_0000);
        // too fast a tick raises its status bit
        wr(ADDR_IRQ_MASK, 8'h04);
        wr(ADDR_CLOCK, 8'h83);
        rdc("tick bad", ADDR_IRQ_STATUS, 32'h0000_0004, 32'h0000_0004);
        check("irq bad", 32'(irq), 32'h0000_0001);
        check("sys div", 32'(system_clock_divider), 32'h0000_0003);
        for (int d = 0; d < 8; d += 3) begin
            // system divider zero keeps tick legal
            wr(ADDR_CLOCK, 8'h80 | (8'(d) << 3));
            repeat (8) @(posedge clk_sys);
            cnt = 0;
            prev = 1'b0;
            repeat (256) begin
                @(posedge clk_sys);
                if (timer_tick === 1'b1) cnt += (d > 0 && prev === 1'b1) ? 1000 : 1;
                prev = timer_tick;
            end
            check("ticks", 32'(cnt), 32'(256 >> d));
        end
        wr(ADDR_IRQ_STATUS, 8'h07);
        check("irq clr", 32'(irq), 32'h0000_0000);
        wr(ADDR_ENTRY, 8'h01);
        repeat (2) @(posedge clk_sys);
        check("run strobe", 32'(power_state), 32'h0000_0000);
        for (int m = 1; m < 4; m++) begin
            // mask the wake bit off in deep sleep only
            wr(ADDR_IRQ_MASK, (m == 2) ? 8'h00 : 8'h01);
            wr(ADDR_STATE, 8'(m));
            check("no strobe", 32'(power_state), 32'h0000_0000);
            wr(ADDR_ENTRY, 8'h01);
            repeat (2) @(posedge clk_sys);
            check("sleep", 32'(power_state), 32'(m));
            check("scrub", 32'(scrub_sub_range), 32'(m > 1));
            check("retain", 32'(retain_upper_ram), 32'h0000_0001);
            // crystal held unstable so the rc phase is visible
            xtal_ready <= 1'b0;
            wake_timer_irq <= 1'b1;
            repeat (3) @(posedge clk_sys);
            wake_timer_irq <= 1'b0;
            if (m == 3) begin
                check("halt timer", 32'(power_state), 32'h0000_0003);
                wake_pin_irq <= 1'b1;
                @(posedge clk_sys);
                wake_pin_irq <= 1'b0;
            end
            repeat (3) @(posedge clk_sys);
            check("woken", 32'(power_state), 32'h0000_0000);
            check("rc resume", 32'(main_src_rc), 32'h0000_0001);
            xtal_ready <= 1'b1;
            repeat (3) @(posedge clk_sys);
            check("xtal resume", 32'(main_src_rc), 32'h0000_0000);
            check("irq wake", 32'(irq), 32'(m != 2));
            rdc("wake sts", ADDR_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
            rdc("mode clr", ADDR_STATE, 32'h0000_0003, 32'h0000_0000);
            rdc("strobe 0", ADDR_ENTRY, 32'h0000_0003, 32'h0000_0000);
            wr(ADDR_IRQ_STATUS, 8'h07);
        end
        wr(ADDR_STATE, 8'h04);
        check("rc pd", 32'(rc_power_en), 32'h0000_0000);
        end_sim;
    end

    initial begin
        #200_000;
        n_errors++;
        end_sim;
    end
endmodule // pmtc_top_tb

bind pmtc_top pmtc_top_asserts #(.HAS_USB(HAS_USB), .TICK_CNT_W(TICK_CNT_W)) pmtc_top_asserts_i (.*);
